// *** rtl/vrs_params.svh ***
// Constants for the vector and reset select block: offsets, fields, vectors, reset values.
`ifndef VRS_PARAMS_SVH
`define VRS_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register bus geometry and register indices.
// ----------------------------------------------------------------------------
`define VRS_ADDR_W      4
`define VRS_DATA_W      16
`define VRS_REG_ENABLE  4'h0
`define VRS_REG_PIN_EN  4'h1
`define VRS_REG_STATUS  4'h2
`define VRS_REG_MASK    4'h3
`define VRS_REG_VECTOR  4'h4
`define VRS_REG_SOURCE  4'h5

// ----------------------------------------------------------------------------
// Bit positions inside the enable register.
// ----------------------------------------------------------------------------
`define VRS_EN_LOCK     0
`define VRS_EN_SCM      1
`define VRS_EN_CC       2
`define VRS_EN_CBE      3
`define VRS_EN_WUP      4
`define VRS_EN_CSC      5
`define VRS_EN_OVR      6
`define VRS_EN_RXF      7
`define VRS_EN_TXE_LO   8
`define VRS_EN_TXE_HI   10
`define VRS_EN_SDN      11
`define VRS_EN_LVI      12
`define VRS_EN_RTI      13
`define VRS_EN_W        14

// ----------------------------------------------------------------------------
// Event positions, in falling priority, shared by status, mask and requests.
// ----------------------------------------------------------------------------
`define VRS_EV_RTI      0
`define VRS_EV_LOCK     1
`define VRS_EV_SCM      2
`define VRS_EV_FLASH    3
`define VRS_EV_WUP      4
`define VRS_EV_ERR      5
`define VRS_EV_RX       6
`define VRS_EV_TX       7
`define VRS_EV_PORTP    8
`define VRS_EV_SDN      9
`define VRS_EV_LVI      10
`define VRS_EV_N        11
`define VRS_PIN_N       8
`define VRS_TXE_N       3
`define VRS_SRC_N       5

// ----------------------------------------------------------------------------
// Vector addresses.
// ----------------------------------------------------------------------------
`define VRS_VEC_POR     16'hFFFE
`define VRS_VEC_CLKMON  16'hFFFC
`define VRS_VEC_WDOG    16'hFFFA
`define VRS_VEC_RTI     16'hFFF0
`define VRS_VEC_LOCK    16'hFFC6
`define VRS_VEC_SCM     16'hFFC4
`define VRS_VEC_FLASH   16'hFFB8
`define VRS_VEC_WUP     16'hFFB6
`define VRS_VEC_ERR     16'hFFB4
`define VRS_VEC_RX      16'hFFB2
`define VRS_VEC_TX      16'hFFB0
`define VRS_VEC_PORTP   16'hFF8E
`define VRS_VEC_SDN     16'hFF8C
`define VRS_VEC_LVI     16'hFF8A
`define VRS_VEC_NONE    16'h0000

// ----------------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------------
`define VRS_ENABLE_RST  14'h0000
`define VRS_PIN_RST     8'h00
`define VRS_EV_RST      11'h000
`define VRS_DATA_RST    16'h0000
`define VRS_SRC_RST     5'h00

`endif

// *** rtl/vrs_pkg.sv ***
// Types shared by the vector and reset select block.
`default_nettype none
`include "vrs_params.svh"

package vrs_pkg;

   // -------------------------------------------------------------------------
   // Common word types.
   // -------------------------------------------------------------------------
   typedef logic [`VRS_DATA_W-1:0] vrs_vec_t;
   typedef logic [`VRS_ADDR_W-1:0] vrs_addr_t;
   typedef logic [`VRS_EV_N-1:0]   vrs_ev_t;
   typedef logic [`VRS_SRC_N-1:0]  vrs_src_t;

   // Reset sources in the order they sit in a source vector.
   typedef enum logic [2:0] {
      VRS_SRC_POR,
      VRS_SRC_EXT,
      VRS_SRC_LVR,
      VRS_SRC_CLKMON,
      VRS_SRC_WDOG
   } vrs_src_e;

endpackage : vrs_pkg

`default_nettype wire

// *** rtl/vrs_sync.sv ***
// Three-stage synchroniser with agreement filter for the reset source levels.
`timescale 1ns/10ps
`default_nettype none
`include "vrs_params.svh"

module vrs_sync (
   input  wire logic   clk,
   input  wire logic   rst_b,
   input  wire logic   ce,
   vrs_sync_if.syncer  sif
);

   logic [`VRS_SRC_N-1:0] s1_q;
   logic [`VRS_SRC_N-1:0] s2_q;
   logic [`VRS_SRC_N-1:0] s3_q;
   logic [`VRS_SRC_N-1:0] clean_q;

   // -------------------------------------------------------------------------
   // Shift chain; only the second stage reads the first.
   // -------------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s1_q <= `VRS_SRC_RST;
         s2_q <= `VRS_SRC_RST;
         s3_q <= `VRS_SRC_RST;
      end else if (ce) begin
         s1_q <= sif.raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // A bit changes only when the last two stages agree, so one-cycle glitches are dropped.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         clean_q <= `VRS_SRC_RST;
      end else if (ce) begin
         clean_q <= (s3_q & ~(s2_q ^ s3_q)) | (clean_q & (s2_q ^ s3_q));
      end
   end

   assign sif.clean = clean_q;

endmodule : vrs_sync

`default_nettype wire

// *** rtl/vrs_sync_if.sv ***
// Interface carrying raw and cleaned reset source levels to the synchroniser.
`timescale 1ns/10ps
`default_nettype none
`include "vrs_params.svh"

interface vrs_sync_if;
   logic [`VRS_SRC_N-1:0] raw;
   logic [`VRS_SRC_N-1:0] clean;

   modport syncer (input raw, output clean);
   modport user   (output raw, input clean);
endinterface : vrs_sync_if

`default_nettype wire

// *** rtl/vrs_top.sv ***
// Interrupt vector and reset vector selection with enable, status and mask registers.
`timescale 1ns/10ps
`default_nettype none
`include "vrs_params.svh"

module vrs_top (
   input  wire logic                      clk,
   input  wire logic                      rst_b,
   input  wire logic                      ce,
   input  wire logic [`VRS_ADDR_W-1:0]    addr,
   input  wire logic [`VRS_DATA_W-1:0]    wr_data,
   input  wire logic                      wr_en,
   input  wire logic                      rd_en,
   output logic      [`VRS_DATA_W-1:0]    rd_data_q,
   input  wire logic                      i_bit,
   input  wire logic                      rti_flag,
   input  wire logic                      lock_flag,
   input  wire logic                      self_clock_flag,
   input  wire logic                      cmd_complete_flag,
   input  wire logic                      cmd_buffer_empty_flag,
   input  wire logic                      can_wakeup_flag,
   input  wire logic                      can_status_change_flag,
   input  wire logic                      can_overrun_flag,
   input  wire logic                      can_rx_full_flag,
   input  wire logic [`VRS_TXE_N-1:0]     can_tx_empty_flags,
   input  wire logic [`VRS_PIN_N-1:0]     port_p_flags,
   input  wire logic                      shutdown_flag,
   input  wire logic                      low_voltage_indication,
   input  wire logic                      por_req,
   input  wire logic                      reset_pin_b,
   input  wire logic                      low_voltage_reset_req,
   input  wire logic                      clock_monitor_req,
   input  wire logic                      watchdog_req,
   output logic      [`VRS_DATA_W-1:0]    vec_addr_q,
   output logic                           vec_valid_q,
   output logic                           vec_is_reset_q,
   output logic                           irq_q
);

   // ----------------------------------------------------------------------------
   // Declarations.
   // ----------------------------------------------------------------------------
   logic [`VRS_EN_W-1:0]   enable_q;
   logic [`VRS_PIN_N-1:0]  pin_en_q;
   vrs_pkg::vrs_ev_t       status_q;
   vrs_pkg::vrs_ev_t       mask_q;
   vrs_pkg::vrs_ev_t       req_prev_q;
   vrs_pkg::vrs_ev_t       req;
   vrs_pkg::vrs_ev_t       status_d;
   vrs_pkg::vrs_src_t      rst_src;
   logic                   rst_any;
   logic                   status_rd;
   vrs_pkg::vrs_vec_t      vec_d;

   vrs_sync_if sif ();

   // ----------------------------------------------------------------------------
   // Functions.
   // ----------------------------------------------------------------------------

   // Reset vector by priority; power-on, pin and low voltage share priority one.
   function automatic vrs_pkg::vrs_vec_t pick_rst(input vrs_pkg::vrs_src_t src);
      vrs_pkg::vrs_vec_t v;
      v = `VRS_VEC_NONE;
      if (src[vrs_pkg::VRS_SRC_POR] || src[vrs_pkg::VRS_SRC_EXT] ||
          src[vrs_pkg::VRS_SRC_LVR]) begin
         v = `VRS_VEC_POR;
      end else if (src[vrs_pkg::VRS_SRC_CLKMON]) begin
         v = `VRS_VEC_CLKMON;
      end else if (src[vrs_pkg::VRS_SRC_WDOG]) begin
         v = `VRS_VEC_WDOG;
      end
      return v;
   endfunction : pick_rst

   // Interrupt vector of the highest priority request; only listed slots exist.
   function automatic vrs_pkg::vrs_vec_t pick_irq(input vrs_pkg::vrs_ev_t r);
      vrs_pkg::vrs_vec_t v;
      v = `VRS_VEC_NONE;
      if (r[`VRS_EV_RTI]) begin
         v = `VRS_VEC_RTI;
      end else if (r[`VRS_EV_LOCK]) begin
         v = `VRS_VEC_LOCK;
      end else if (r[`VRS_EV_SCM]) begin
         v = `VRS_VEC_SCM;
      end else if (r[`VRS_EV_FLASH]) begin
         v = `VRS_VEC_FLASH;
      end else if (r[`VRS_EV_WUP]) begin
         v = `VRS_VEC_WUP;
      end else if (r[`VRS_EV_ERR]) begin
         v = `VRS_VEC_ERR;
      end else if (r[`VRS_EV_RX]) begin
         v = `VRS_VEC_RX;
      end else if (r[`VRS_EV_TX]) begin
         v = `VRS_VEC_TX;
      end else if (r[`VRS_EV_PORTP]) begin
         v = `VRS_VEC_PORTP;
      end else if (r[`VRS_EV_SDN]) begin
         v = `VRS_VEC_SDN;
      end else if (r[`VRS_EV_LVI]) begin
         v = `VRS_VEC_LVI;
      end
      return v;
   endfunction : pick_irq

   // ----------------------------------------------------------------------------
   // Reset source synchronisation; the pin is active low and inverted here.
   // ----------------------------------------------------------------------------
   assign sif.raw = {watchdog_req, clock_monitor_req, low_voltage_reset_req,
                     ~reset_pin_b, por_req};

   vrs_sync u_sync (
      .clk   (clk),
      .rst_b (rst_b),
      .ce    (ce),
      .sif   (sif)
   );

   assign rst_src = sif.clean;
   assign rst_any = |rst_src;

   // ----------------------------------------------------------------------------
   // Local enables gate each source before the I bit is applied.
   // ----------------------------------------------------------------------------
   always_comb begin
      req = `VRS_EV_RST;
      req[`VRS_EV_RTI]   = rti_flag & enable_q[`VRS_EN_RTI];
      req[`VRS_EV_LOCK]  = lock_flag & enable_q[`VRS_EN_LOCK];
      req[`VRS_EV_SCM]   = self_clock_flag & enable_q[`VRS_EN_SCM];
      req[`VRS_EV_FLASH] = (cmd_complete_flag & enable_q[`VRS_EN_CC]) |
                           (cmd_buffer_empty_flag & enable_q[`VRS_EN_CBE]);
      req[`VRS_EV_WUP]   = can_wakeup_flag & enable_q[`VRS_EN_WUP];
      req[`VRS_EV_ERR]   = (can_status_change_flag & enable_q[`VRS_EN_CSC]) |
                           (can_overrun_flag & enable_q[`VRS_EN_OVR]);
      req[`VRS_EV_RX]    = can_rx_full_flag & enable_q[`VRS_EN_RXF];
      req[`VRS_EV_TX]    = |(can_tx_empty_flags &
                             enable_q[`VRS_EN_TXE_HI:`VRS_EN_TXE_LO]);
      req[`VRS_EV_PORTP] = |(port_p_flags & pin_en_q);
      req[`VRS_EV_SDN]   = shutdown_flag & enable_q[`VRS_EN_SDN];
      req[`VRS_EV_LVI]   = low_voltage_indication & enable_q[`VRS_EN_LVI];
   end

   // ----------------------------------------------------------------------------
   // Vector selection: resets ignore the I bit, everything else is masked by it.
   // ----------------------------------------------------------------------------
   always_comb begin
      if (rst_any) begin
         vec_d = pick_rst(rst_src);
      end else if (!i_bit) begin
         vec_d = pick_irq(req);
      end else begin
         vec_d = `VRS_VEC_NONE;
      end
   end

   // The vector is registered so the core sees a stable address one cycle on.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         vec_addr_q     <= `VRS_VEC_NONE;
         vec_valid_q    <= 1'b0;
         vec_is_reset_q <= 1'b0;
      end else if (ce) begin
         vec_addr_q     <= vec_d;
         vec_valid_q    <= (vec_d != `VRS_VEC_NONE);
         vec_is_reset_q <= rst_any;
      end
   end

   // ----------------------------------------------------------------------------
   // Software registers. A reset source clears them; memory is never touched here.
   // ----------------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         enable_q <= `VRS_ENABLE_RST;
         pin_en_q <= `VRS_PIN_RST;
         mask_q   <= `VRS_EV_RST;
      end else if (ce) begin
         if (rst_any) begin
            enable_q <= `VRS_ENABLE_RST;
            pin_en_q <= `VRS_PIN_RST;
            mask_q   <= `VRS_EV_RST;
         end else if (wr_en) begin
            if (addr == `VRS_REG_ENABLE) begin
               enable_q <= wr_data[`VRS_EN_W-1:0];
            end else if (addr == `VRS_REG_PIN_EN) begin
               pin_en_q <= wr_data[`VRS_PIN_N-1:0];
            end else if (addr == `VRS_REG_MASK) begin
               mask_q <= wr_data[`VRS_EV_N-1:0];
            end
         end
      end
   end

   // ----------------------------------------------------------------------------
   // Sticky event status. A new request in the clearing cycle survives the read.
   // ----------------------------------------------------------------------------
   assign status_rd = rd_en && (addr == `VRS_REG_STATUS);

   always_comb begin
      status_d = status_rd ? `VRS_EV_RST : status_q;
      status_d = status_d | (req & ~req_prev_q);
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         status_q   <= `VRS_EV_RST;
         req_prev_q <= `VRS_EV_RST;
      end else if (ce) begin
         req_prev_q <= req;
         status_q   <= rst_any ? `VRS_EV_RST : status_d;
      end
   end

   // Level interrupt registered from the next status value so it tracks the clear exactly.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_q <= 1'b0;
      end else if (ce) begin
         irq_q <= !rst_any && |(status_d & mask_q);
      end
   end

   // ----------------------------------------------------------------------------
   // Read data, valid only in the cycle after the strobe; unmapped reads give zero.
   // ----------------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_data_q <= `VRS_DATA_RST;
      end else if (ce) begin
         rd_data_q <= `VRS_DATA_RST;
         if (rd_en) begin
            if (addr == `VRS_REG_ENABLE) begin
               rd_data_q <= {{(`VRS_DATA_W-`VRS_EN_W){1'b0}}, enable_q};
            end else if (addr == `VRS_REG_PIN_EN) begin
               rd_data_q <= {{(`VRS_DATA_W-`VRS_PIN_N){1'b0}}, pin_en_q};
            end else if (addr == `VRS_REG_STATUS) begin
               rd_data_q <= {{(`VRS_DATA_W-`VRS_EV_N){1'b0}}, status_q};
            end else if (addr == `VRS_REG_MASK) begin
               rd_data_q <= {{(`VRS_DATA_W-`VRS_EV_N){1'b0}}, mask_q};
            end else if (addr == `VRS_REG_VECTOR) begin
               rd_data_q <= vec_addr_q;
            end else if (addr == `VRS_REG_SOURCE) begin
               rd_data_q <= {{(`VRS_DATA_W-`VRS_SRC_N){1'b0}}, rst_src};
            end
         end
      end
   end

   // ----------------------------------------------------------------------------
   // Assertions.
   // ----------------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   property p_lock_vec;
      ce && !rst_any && !i_bit && req[`VRS_EV_LOCK] && !req[`VRS_EV_RTI]
         |=> vec_addr_q == `VRS_VEC_LOCK && vec_valid_q;
   endproperty
   a_lock_vec: assert property (p_lock_vec) else $error("lock vector wrong");

   property p_scm_vec;
      ce && !rst_any && !i_bit && self_clock_flag && enable_q[`VRS_EN_SCM] &&
         req[`VRS_EV_SCM-1:0] == '0 |=> vec_addr_q == `VRS_VEC_SCM;
   endproperty
   a_scm_vec: assert property (p_scm_vec) else $error("self clock vector wrong");

   property p_flash_vec;
      ce && !rst_any && !i_bit && cmd_buffer_empty_flag && enable_q[`VRS_EN_CBE] &&
         req[`VRS_EV_FLASH-1:0] == '0 |=> vec_addr_q == `VRS_VEC_FLASH;
   endproperty
   a_flash_vec: assert property (p_flash_vec) else $error("flash vector wrong");

   property p_can_tx_vec;
      ce && !rst_any && !i_bit && req[`VRS_EV_TX] && req[`VRS_EV_TX-1:0] == '0
         |=> vec_addr_q == `VRS_VEC_TX;
   endproperty
   a_can_tx_vec: assert property (p_can_tx_vec) else $error("can tx vector wrong");

   property p_portp_vec;
      ce && !rst_any && !i_bit && |(port_p_flags & pin_en_q) &&
         req[`VRS_EV_PORTP-1:0] == '0 |=> vec_addr_q == `VRS_VEC_PORTP;
   endproperty
   a_portp_vec: assert property (p_portp_vec) else $error("port vector wrong");

   property p_lvi_vec;
      ce && !rst_any && !i_bit && req == (`VRS_EV_N'(1) << `VRS_EV_LVI)
         |=> vec_addr_q == `VRS_VEC_LVI && vec_valid_q && !vec_is_reset_q;
   endproperty
   a_lvi_vec: assert property (p_lvi_vec) else $error("low voltage vector wrong");

   property p_por_vec;
      ce && (rst_src[vrs_pkg::VRS_SRC_POR] || rst_src[vrs_pkg::VRS_SRC_EXT])
         |=> vec_addr_q == `VRS_VEC_POR && vec_is_reset_q;
   endproperty
   a_por_vec: assert property (p_por_vec) else $error("reset vector wrong");

   property p_clkmon_vec;
      ce && rst_src[vrs_pkg::VRS_SRC_CLKMON] && rst_src[2:0] == '0
         |=> vec_addr_q == `VRS_VEC_CLKMON;
   endproperty
   a_clkmon_vec: assert property (p_clkmon_vec) else $error("clock monitor vector wrong");

   property p_wdog_vec;
      ce && rst_src == (`VRS_SRC_N'(1) << vrs_pkg::VRS_SRC_WDOG) |=> vec_addr_q == `VRS_VEC_WDOG;
   endproperty
   a_wdog_vec: assert property (p_wdog_vec) else $error("watchdog vector wrong");

   property p_reset_clear;
      ce && rst_any |=> enable_q == '0 && mask_q == '0 && status_q == '0 && !irq_q;
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("registers not cleared");

   property p_ibit_mask;
      ce && !rst_any && i_bit |=> !vec_valid_q;
   endproperty
   a_ibit_mask: assert property (p_ibit_mask) else $error("I bit did not mask");

   property p_no_reserved;
      vec_valid_q |-> vec_addr_q inside {`VRS_VEC_POR, `VRS_VEC_CLKMON, `VRS_VEC_WDOG,
         `VRS_VEC_RTI, `VRS_VEC_LOCK, `VRS_VEC_SCM, `VRS_VEC_FLASH, `VRS_VEC_WUP,
         `VRS_VEC_ERR, `VRS_VEC_RX, `VRS_VEC_TX, `VRS_VEC_PORTP, `VRS_VEC_SDN, `VRS_VEC_LVI};
   endproperty
   a_no_reserved: assert property (p_no_reserved) else $error("reserved vector out");

   c_irq_vec:    cover property (ce && !i_bit && req[`VRS_EV_SDN] ##1 vec_addr_q == `VRS_VEC_SDN);
   c_multi_rst:  cover property (rst_src[vrs_pkg::VRS_SRC_LVR] && rst_src[vrs_pkg::VRS_SRC_WDOG]);
   c_status_irq: cover property (irq_q ##1 status_rd ##1 !irq_q);

endmodule : vrs_top

`default_nettype wire

// *** verif/vrs_cpu_model.sv ***
// Processor core stand-in that owns the I bit and latches each fetched vector.
`timescale 1ns/10ps
`default_nettype none
`include "vrs_params.svh"

module vrs_cpu_model (
   input  wire logic                   clk,
   input  wire logic                   rst_b,
   input  wire logic                   mask_req,
   input  wire logic [`VRS_DATA_W-1:0] vec_addr_q,
   input  wire logic                   vec_valid_q,
   output logic                        i_bit,
   output logic      [`VRS_DATA_W-1:0] fetched_q
);
   // The core leaves reset masked, so nothing maskable is taken before software clears I.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         i_bit     <= 1'b1;
         fetched_q <= `VRS_VEC_NONE;
      end else begin
         i_bit <= mask_req;
         if (vec_valid_q) begin
            fetched_q <= vec_addr_q;
         end
      end
   end
endmodule : vrs_cpu_model

`default_nettype wire

// *** verif/vrs_top_tb_top.sv ***
// Self-checking bench for the vector and reset select block.
`timescale 1ns/10ps
`default_nettype none
`include "vrs_params.svh"

module vrs_top_tb_top;
   logic        clk = 1'b0;
   logic        rst_b = 1'b0;
   logic [3:0]  addr = 4'h0;
   logic [15:0] wr_data = 16'h0000;
   logic        wr_en = 1'b0;
   logic        rd_en = 1'b0;
   logic        mask_req = 1'b0;
   logic        ce = 1'b1;
   logic        alt = 1'b0;
   logic [10:0] flags = 11'h000;
   logic [4:0]  src = 5'h00;
   logic [15:0] rd_data_q, vec_addr_q, fetched_q;
   logic        vec_valid_q, vec_is_reset_q, irq_q, i_bit;
   int          mismatches = 0;
   int          checked = 0;
   int          cycles = 0;
   logic [15:0] vtab [11] = '{16'hFFF0, 16'hFFC6, 16'hFFC4, 16'hFFB8, 16'hFFB6, 16'hFFB4,
                              16'hFFB2, 16'hFFB0, 16'hFF8E, 16'hFF8C, 16'hFF8A};
   logic [4:0]  rcase [7] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h18, 5'h11};

   // The alt bit steers each shared slot's flag onto its second enable path.
   vrs_top u_vrs_top (.clk(clk), .rst_b(rst_b), .ce(ce), .addr(addr), .wr_data(wr_data),
      .wr_en(wr_en), .rd_en(rd_en), .rd_data_q(rd_data_q), .i_bit(i_bit),
      .rti_flag(flags[0]), .lock_flag(flags[1]), .self_clock_flag(flags[2]),
      .cmd_complete_flag(flags[3] & ~alt), .cmd_buffer_empty_flag(flags[3] & alt),
      .can_wakeup_flag(flags[4]), .can_status_change_flag(flags[5] & ~alt),
      .can_overrun_flag(flags[5] & alt), .can_rx_full_flag(flags[6]),
      .can_tx_empty_flags({flags[7] & alt, 1'b0, flags[7] & ~alt}),
      .port_p_flags({flags[8] & alt, 6'h00, flags[8] & ~alt}),
      .shutdown_flag(flags[9]), .low_voltage_indication(flags[10]), .por_req(src[0]),
      .reset_pin_b(~src[1]), .low_voltage_reset_req(src[2]), .clock_monitor_req(src[3]),
      .watchdog_req(src[4]), .vec_addr_q(vec_addr_q), .vec_valid_q(vec_valid_q),
      .vec_is_reset_q(vec_is_reset_q), .irq_q(irq_q));

   vrs_cpu_model u_vrs_cpu_model (.clk(clk), .rst_b(rst_b), .mask_req(mask_req),
      .vec_addr_q(vec_addr_q), .vec_valid_q(vec_valid_q), .i_bit(i_bit),
      .fetched_q(fetched_q));

   // A 50 ns clock; a runaway test is stopped well past the expected few hundred cycles.
   always #25 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         give_verdict();
      end
   end

   // -------------------------------------------------------------------------
   // Bus tasks and comparison.
   // -------------------------------------------------------------------------
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp

   // Outputs are looked at 1 ns after the edge so that edge's updates have landed.
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a; wr_data <= d; wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask : wr

   // Read data stand only in the cycle after the strobe, so they are taken there.
   task automatic rd(input logic [3:0] a, input logic [15:0] exp);
      @(posedge clk);
      addr <= a; rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 cmp(rd_data_q, exp);
   endtask : rd

   task automatic give_verdict();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : give_verdict

   // Expected reset vector worked out from the source priorities.
   function automatic logic [15:0] rst_vec(input logic [4:0] s);
      if (|s[2:0]) return 16'hFFFE;
      if (s[3]) return 16'hFFFC;
      return 16'hFFFA;
   endfunction : rst_vec

   // -------------------------------------------------------------------------
   // Main sequence.
   // -------------------------------------------------------------------------
   initial begin
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      for (int r = 0; r < 7; r++) rd(r[3:0], 16'h0000);
      cmp(vec_addr_q, 16'h0000);
      wr(`VRS_REG_MASK, 16'h07FF);
      @(posedge clk) flags[1] <= 1'b1;
      tick(4);
      cmp({15'h0, vec_valid_q}, 16'h0000);
      @(posedge clk) flags <= 11'h000;
      wr(`VRS_REG_ENABLE, 16'h3FFF);
      wr(`VRS_REG_PIN_EN, 16'h00FF);
      rd(`VRS_REG_STATUS, 16'h0000);
      // Each source alone, twice so both enable paths of shared slots are used.
      for (int i = 0; i < 22; i++) begin
         @(posedge clk) begin flags <= 11'(1 << (i % 11)); alt <= (i > 10); end
         tick(4);
         cmp(vec_addr_q, vtab[i % 11]);
         cmp({15'h0, irq_q}, 16'h0001);
         rd(`VRS_REG_STATUS, 16'(1 << (i % 11)));
         tick(1);
         cmp({15'h0, irq_q}, 16'h0000);
         @(posedge clk) flags <= 11'h000;
      end
      // With I set even the real-time source is held off; clearing I gives it first place.
      // I is set a cycle ahead, since the core registers it before the block sees it.
      @(posedge clk) mask_req <= 1'b1;
      @(posedge clk) flags <= 11'h7FF;
      tick(4);
      cmp({15'h0, vec_valid_q}, 16'h0000);
      @(posedge clk) mask_req <= 1'b0;
      tick(4);
      cmp(vec_addr_q, 16'hFFF0);
      // With the clock enable low every flop in the block holds, so the dropped flags go unseen.
      @(posedge clk) begin ce <= 1'b0; flags <= 11'h000; end
      tick(4);
      cmp(vec_addr_q, 16'hFFF0);
      cmp({15'h0, irq_q}, 16'h0001);
      @(posedge clk) ce <= 1'b1;
      wr(`VRS_REG_MASK, 16'h0000);
      rd(`VRS_REG_STATUS, 16'h07FF);
      tick(2);
      cmp({15'h0, irq_q}, 16'h0000);
      cmp(fetched_q, 16'hFFF0);
      // Reset sources alone and together, with I set and every flag raised.
      foreach (rcase[k]) begin
         @(posedge clk) flags <= 11'h000;
         wr(`VRS_REG_ENABLE, 16'h3FFF);
         @(posedge clk) begin src <= rcase[k]; flags <= 11'h7FF; mask_req <= 1'b1; end
         tick(8);
         cmp(vec_addr_q, rst_vec(rcase[k]));
         cmp({15'h0, vec_is_reset_q}, 16'h0001);
         rd(`VRS_REG_SOURCE, {11'h0, rcase[k]});
         wr(`VRS_REG_MASK, 16'h07FF);
         @(posedge clk) src <= 5'h00;
         tick(8);
         rd(`VRS_REG_ENABLE, 16'h0000);
         rd(`VRS_REG_MASK, 16'h0000);
      end
      give_verdict();
   end
endmodule : vrs_top_tb_top

`default_nettype wire
